// file: src/crf_pkg.sv
// Shared constants and types of the core register file and status flags.
package crf_pkg;
    localparam int unsigned NUM_REGS = 32;
    localparam int unsigned REG_W = 8;
    localparam int unsigned ADDR_W = 5;
    localparam logic [4:0] PTR_X_LO = 5'h1a;
    localparam logic [4:0] PTR_X_HI = 5'h1b;
    localparam logic [4:0] PTR_Y_LO = 5'h1c;
    localparam logic [4:0] PTR_Y_HI = 5'h1d;
    localparam logic [4:0] PTR_Z_LO = 5'h1e;
    localparam logic [4:0] PTR_Z_HI = 5'h1f;
    localparam logic [15:0] DS_REG_LAST = 16'h001f;
    localparam logic [15:0] DS_IO_FIRST = 16'h0020;
    localparam logic [15:0] DS_IO_LAST = 16'h005f;
    localparam logic [15:0] DS_EXT_FIRST = 16'h0060;
    localparam logic [15:0] DS_EXT_LAST = 16'h00ff;
    localparam logic [5:0] IO_STATUS_FLAGS = 6'h3f;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int unsigned FLAG_I = 7;
    localparam int unsigned FLAG_T = 6;
    localparam int unsigned FLAG_H = 5;
    localparam int unsigned FLAG_S = 4;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_C = 0;
    typedef enum logic [3:0] {
        CRF_SCHEME_NONE = 4'h1,
        CRF_SCHEME_1OP8 = 4'h2,
        CRF_SCHEME_2OP8 = 4'h4,
        CRF_SCHEME_2OP16 = 4'h8
    } crf_scheme_t;
    typedef enum logic [2:0] {
        CRF_ALU_ADD = 3'h0,
        CRF_ALU_SUB = 3'h1,
        CRF_ALU_AND = 3'h2,
        CRF_ALU_OR = 3'h3,
        CRF_ALU_XOR = 3'h4,
        CRF_ALU_MOV = 3'h5,
        CRF_ALU_ADIW = 3'h6,
        CRF_ALU_SBIW = 3'h7
    } crf_alu_op_t;
endpackage

// file: src/crf_alu_if.sv
`timescale 1ns/100ps
// Operand and result bundle between the register file top and its ALU.
interface crf_alu_if;
    crf_pkg::crf_alu_op_t op;
    logic carry_in;
    logic [7:0] opa;
    logic [7:0] opb;
    logic [15:0] opw;
    logic [15:0] result;
    logic [7:0] flags;
    modport core (output op, output carry_in, output opa, output opb, output opw,
        input result, input flags);
    modport alu (input op, input carry_in, input opa, input opb, input opw,
        output result, output flags);
endinterface

// file: src/crf_alu.sv
`timescale 1ns/100ps
// Single-cycle combinational ALU producing a result and next arithmetic flags.
module crf_alu (
    crf_alu_if.alu bus
);
    logic [8:0] sum8;
    logic [4:0] nib;
    logic [16:0] sum16;
    logic [7:0] r8;
    logic v8;
    logic n;
    logic v;
    logic wide;
    assign wide = (bus.op == crf_pkg::CRF_ALU_ADIW) || (bus.op == crf_pkg::CRF_ALU_SBIW);
    assign sum8 = (bus.op == crf_pkg::CRF_ALU_SUB) ?
        ({1'b0, bus.opa} - {1'b0, bus.opb} - {8'h00, bus.carry_in}) :
        ({1'b0, bus.opa} + {1'b0, bus.opb} + {8'h00, bus.carry_in});
    // Half carry taken from the bit 3 to bit 4 boundary.
    assign nib = (bus.op == crf_pkg::CRF_ALU_SUB) ?
        ({1'b0, bus.opa[3:0]} - {1'b0, bus.opb[3:0]} - {4'h0, bus.carry_in}) :
        ({1'b0, bus.opa[3:0]} + {1'b0, bus.opb[3:0]} + {4'h0, bus.carry_in});
    assign sum16 = (bus.op == crf_pkg::CRF_ALU_SBIW) ?
        ({1'b0, bus.opw} - {9'h000, bus.opb}) : ({1'b0, bus.opw} + {9'h000, bus.opb});
    assign v8 = (bus.op == crf_pkg::CRF_ALU_SUB) ?
        ((bus.opa[7] ^ bus.opb[7]) & (bus.opa[7] ^ sum8[7])) :
        (~(bus.opa[7] ^ bus.opb[7]) & (bus.opa[7] ^ sum8[7]));
    always_comb begin
        case (bus.op)
            crf_pkg::CRF_ALU_ADD, crf_pkg::CRF_ALU_SUB: r8 = sum8[7:0];
            crf_pkg::CRF_ALU_AND: r8 = bus.opa & bus.opb;
            crf_pkg::CRF_ALU_OR: r8 = bus.opa | bus.opb;
            crf_pkg::CRF_ALU_XOR: r8 = bus.opa ^ bus.opb;
            default: r8 = bus.opb;
        endcase
    end
    assign bus.result = wide ? sum16[15:0] : {8'h00, r8};
    assign n = wide ? sum16[15] : r8[7];
    assign v = wide ? (sum16[15] ^ bus.opw[15]) & ~(bus.op == crf_pkg::CRF_ALU_SBIW ?
        sum16[15] : bus.opw[15]) :
        ((bus.op == crf_pkg::CRF_ALU_ADD) || (bus.op == crf_pkg::CRF_ALU_SUB)) & v8;
    // Bits 7 and 6 are owned by the core and pass as zero here.
    assign bus.flags[7:6] = 2'h0;
    assign bus.flags[5] = ~wide & nib[4];
    assign bus.flags[4] = n ^ v;
    assign bus.flags[3] = v;
    assign bus.flags[2] = n;
    assign bus.flags[1] = wide ? (sum16[15:0] == 16'h0000) : (r8 == 8'h00);
    assign bus.flags[0] = wide ? sum16[16] :
        (((bus.op == crf_pkg::CRF_ALU_ADD) || (bus.op == crf_pkg::CRF_ALU_SUB)) & sum8[8]);
endmodule

// file: src/crf_core.sv
`timescale 1ns/100ps
// Working register file, status flags, data-space decode and prefetch stage.
// Overview of operation
// - Thirty-two 8-bit working registers, each read or written in one cycle.
// - Two operands read, computed and written back within one clock cycle.
// - Six registers also form three 16-bit indirect data pointers, one for tables.
// - Pointers are registers 26/27, 28/29 and 30/31, low byte first.
// - Working registers occupy data addresses 0x00 to 0x1f.
// - Sixty-four I/O addresses, direct or at data addresses 0x20 to 0x5f.
// - Extended I/O at 0x60 to 0xff only by load and store data instructions.
// - Four schemes: 1x8 to 8, 2x8 to 8, 2x8 to 16, 1x16 to 16.
// - Status flags at I/O 0x3f, data 0x5f, all read-write, reset cleared.
// - Bit 7 is global interrupt enable; cleared blocks every interrupt.
// - Taking an interrupt clears bit 7; return and set/clear instructions change it.
// - Bit 6 is a bit copy store loaded and unloaded by bit instructions.
// - Bit 5 is half carry for BCD arithmetic.
// - Bit 4 sign is set to negative XOR overflow by each ALU operation; a status write can load any value.
// - Bit 3 is two's complement overflow.
// - Bit 2 is negative flag.
// - Bit 1 is zero flag.
// - Bit 0 is carry flag.
// - Flags update after every ALU operation.
// - Flags are not saved or restored around interrupts.
// - Next instruction is prefetched while the current one executes.
// - Lower interrupt vector number has higher priority.
module crf_core #(
    parameter int unsigned NUM_IRQ = 8,
    parameter int unsigned INSTR_W = 16
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire crf_pkg::crf_scheme_t scheme_in,
    input wire crf_pkg::crf_alu_op_t alu_op_in,
    input wire logic use_carry_in,
    input wire logic [4:0] src_a_in,
    input wire logic [4:0] src_b_in,
    input wire logic [4:0] dst_in,
    input wire logic use_imm_in,
    input wire logic [7:0] imm_in,
    input wire logic wide_src_in,
    input wire logic [1:0] ptr_sel_in,
    input wire logic io_rd_in,
    input wire logic io_wr_in,
    input wire logic [5:0] io_addr_in,
    input wire logic ds_rd_in,
    input wire logic ds_wr_in,
    input wire logic [15:0] ds_addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [7:0] ext_rd_data_in,
    input wire logic bit_store_instr_in,
    input wire logic bit_load_instr_in,
    input wire logic [2:0] bit_sel_in,
    input wire logic set_global_enable_instr_in,
    input wire logic clear_global_enable_instr_in,
    input wire logic return_from_irq_instr_in,
    input wire logic [NUM_IRQ-1:0] irq_req_in,
    input wire logic [INSTR_W-1:0] pmem_data_in,
    input wire logic fetch_en_in,
    output logic [7:0] rd_data_out,
    output logic [15:0] ptr_out,
    output logic [15:0] table_ptr_out,
    output logic [7:0] status_flags_out,
    output logic io_sel_out,
    output logic ext_sel_out,
    output logic irq_take_out,
    output logic [$clog2(NUM_IRQ)-1:0] irq_num_out,
    output logic [INSTR_W-1:0] instr_out
);
    logic [7:0] work_reg [crf_pkg::NUM_REGS];
    logic [7:0] cpu_status_flags;
    logic [7:0] rd_data;
    logic [INSTR_W-1:0] instr;
    crf_alu_if alu_bus ();

    function automatic logic [15:0] pair_base(input logic [1:0] sel);
        logic [15:0] b;
        b = 16'h0000;
        case (sel)
            2'h0: b = {11'h000, crf_pkg::PTR_X_LO};
            2'h1: b = {11'h000, crf_pkg::PTR_Y_LO};
            default: b = {11'h000, crf_pkg::PTR_Z_LO};
        endcase
        return b;
    endfunction

    wire logic [15:0] pair_full = pair_base(ptr_sel_in);
    wire logic [4:0] pair_lo = pair_full[4:0];
    wire logic [4:0] pair_hi = pair_lo + 5'h01;
    wire logic [15:0] wide_src = {work_reg[pair_hi], work_reg[pair_lo]};
    wire logic [7:0] opa = work_reg[src_a_in];
    wire logic [7:0] opb = use_imm_in ? imm_in : work_reg[src_b_in];
    wire logic alu_active = (scheme_in != crf_pkg::CRF_SCHEME_NONE);
    wire logic ds_reg_hit = (ds_addr_in <= crf_pkg::DS_REG_LAST);
    wire logic ds_io_hit = (ds_addr_in >= crf_pkg::DS_IO_FIRST) &&
        (ds_addr_in <= crf_pkg::DS_IO_LAST);
    wire logic ds_ext_hit = (ds_addr_in >= crf_pkg::DS_EXT_FIRST) &&
        (ds_addr_in <= crf_pkg::DS_EXT_LAST);
    wire logic [5:0] ds_io_addr = 6'(ds_addr_in - crf_pkg::DS_IO_FIRST);
    wire logic sf_io_wr = io_wr_in && (io_addr_in == crf_pkg::IO_STATUS_FLAGS);
    wire logic sf_ds_wr = ds_wr_in && ds_io_hit && (ds_io_addr == crf_pkg::IO_STATUS_FLAGS);
    wire logic sf_wr = sf_io_wr || sf_ds_wr;
    wire logic sf_rd_io = io_rd_in && (io_addr_in == crf_pkg::IO_STATUS_FLAGS);
    wire logic sf_rd_ds = ds_rd_in && ds_io_hit && (ds_io_addr == crf_pkg::IO_STATUS_FLAGS);
    wire logic reg_ds_wr = ds_wr_in && ds_reg_hit;
    wire logic [4:0] reg_ds_idx = ds_addr_in[4:0];

    // Lowest pending number wins, so vector order sets the priority.
    logic [$clog2(NUM_IRQ)-1:0] next_irq_num;
    logic irq_any;
    always_comb begin
        next_irq_num = '0;
        irq_any = 1'b0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (irq_req_in[i]) begin
                next_irq_num = ($clog2(NUM_IRQ))'(i);
                irq_any = 1'b1;
            end
        end
    end
    // A clear instruction in the same cycle blocks the interrupt at once.
    assign irq_take_out = irq_any && cpu_status_flags[crf_pkg::FLAG_I] &&
        !clear_global_enable_instr_in && !sf_wr;
    assign irq_num_out = next_irq_num;

    assign alu_bus.op = alu_op_in;
    assign alu_bus.carry_in = use_carry_in & cpu_status_flags[crf_pkg::FLAG_C];
    assign alu_bus.opa = opa;
    assign alu_bus.opb = opb;
    assign alu_bus.opw = wide_src;
    crf_alu u_alu (
        .bus(alu_bus)
    );

    logic [7:0] next_flags;
    always_comb begin
        next_flags = cpu_status_flags;
        if (alu_active) begin
            next_flags[5:0] = alu_bus.flags[5:0];
        end
        if (bit_store_instr_in) begin
            next_flags[crf_pkg::FLAG_T] = opa[bit_sel_in];
        end
        if (set_global_enable_instr_in || return_from_irq_instr_in) begin
            next_flags[crf_pkg::FLAG_I] = 1'b1;
        end
        if (clear_global_enable_instr_in) begin
            next_flags[crf_pkg::FLAG_I] = 1'b0;
        end
        if (sf_wr) begin
            next_flags = wr_data_in;
        end
        // Nothing is stacked here; software keeps the flags across handlers.
        if (irq_take_out) begin
            next_flags[crf_pkg::FLAG_I] = 1'b0;
        end
    end

    generate
        for (genvar g = 0; g < crf_pkg::NUM_REGS; g++) begin : g_reg
            localparam logic [4:0] IDX = 5'(g);
            wire logic hit_lo = alu_active && (dst_in == IDX);
            wire logic hit_hi = (scheme_in == crf_pkg::CRF_SCHEME_2OP16) &&
                (dst_in + 5'h01 == IDX);
            wire logic hit_ds = reg_ds_wr && (reg_ds_idx == IDX);
            wire logic hit_bl = bit_load_instr_in && (dst_in == IDX);
            logic [7:0] bl_val;
            always_comb begin
                bl_val = work_reg[g];
                bl_val[bit_sel_in] = cpu_status_flags[crf_pkg::FLAG_T];
            end
            always_ff @(posedge sys_clk_in) begin
                if (!rst_n_in) begin
                    work_reg[g] <= 8'h00;
                end else if (hit_ds) begin
                    work_reg[g] <= wr_data_in;
                end else if (hit_hi) begin
                    work_reg[g] <= alu_bus.result[15:8];
                end else if (hit_lo) begin
                    work_reg[g] <= alu_bus.result[7:0];
                end else if (hit_bl) begin
                    work_reg[g] <= bl_val;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cpu_status_flags <= crf_pkg::STATUS_RESET;
        end else begin
            cpu_status_flags <= next_flags;
        end
    end

    // Prefetch register: the next word is latched while the current executes.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            instr <= '0;
        end else if (fetch_en_in) begin
            instr <= pmem_data_in;
        end
    end
    assign instr_out = instr;

    always_comb begin
        rd_data = 8'h00;
        if (sf_rd_io || sf_rd_ds) begin
            rd_data = cpu_status_flags;
        end else if (ds_rd_in && ds_reg_hit) begin
            rd_data = work_reg[reg_ds_idx];
        end else if (ds_rd_in && ds_ext_hit) begin
            rd_data = ext_rd_data_in;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rd_data_out <= 8'h00;
        end else begin
            rd_data_out <= rd_data;
        end
    end

    assign ptr_out = wide_src;
    assign table_ptr_out = {work_reg[crf_pkg::PTR_Z_HI], work_reg[crf_pkg::PTR_Z_LO]};
    assign status_flags_out = cpu_status_flags;
    // Short I/O instructions never reach the extended region.
    assign io_sel_out = (io_rd_in || io_wr_in) || ((ds_rd_in || ds_wr_in) && ds_io_hit);
    assign ext_sel_out = (ds_rd_in || ds_wr_in) && ds_ext_hit;

    a_sign_rule: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        alu_active && !sf_wr |=> status_flags_out[4] ==
        (status_flags_out[2] ^ status_flags_out[3]))
        else $error("sign flag differs from N xor V");
    a_irq_gate: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !status_flags_out[7] |-> !irq_take_out) else $error("interrupt taken while disabled");
    a_irq_clears: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        irq_take_out |=> !status_flags_out[7]) else $error("enable not cleared on entry");
    a_return_from_irq_instr_sets: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        return_from_irq_instr_in && !irq_take_out && !clear_global_enable_instr_in && !sf_wr
        |=> status_flags_out[7]) else $error("return did not set enable");
    a_flag_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        sf_io_wr && !irq_take_out |=> status_flags_out == $past(wr_data_in))
        else $error("status write lost");
    a_reset_flags: assert property (@(posedge sys_clk_in)
        !rst_n_in |=> status_flags_out == 8'h00) else $error("flags not cleared by reset");
    a_zero_flag: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        alu_active && !sf_wr && (alu_bus.result == 16'h0000) |=> status_flags_out[1])
        else $error("zero flag missing");
    a_prefetch: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        fetch_en_in |=> instr_out == $past(pmem_data_in)) else $error("prefetch lost");
    a_ds_reg_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        ds_rd_in && ds_reg_hit && !sf_rd_io |=> rd_data_out == $past(rd_data))
        else $error("register read wrong");
    c_irq_taken: cover property (@(posedge sys_clk_in) irq_take_out);
    c_wide_op: cover property (@(posedge sys_clk_in) scheme_in == crf_pkg::CRF_SCHEME_2OP16);
    c_ext_access: cover property (@(posedge sys_clk_in) ext_sel_out);
endmodule

// file: tb/crf_far_model.sv
// Behavioural model of the program memory and extended data region facing the core.
`timescale 1ns/100ps
module crf_far_model (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] ds_addr_in,
    output logic [15:0] pmem_data_out,
    output logic [7:0] ext_data_out
);
    logic [7:0] word_cnt;
    // The word changes every cycle, so a stage that fails to refetch shows a stale value.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            word_cnt <= 8'h00;
        end else begin
            word_cnt <= word_cnt + 8'h01;
        end
    end
    assign pmem_data_out = {8'h9c, word_cnt};
    assign ext_data_out = ~ds_addr_in[7:0];
endmodule

// file: tb/cpu_register_file_and_status_flags_tb_top.sv
// Self-checking bench of the core register file and status flags.
`timescale 1ns/100ps
module cpu_register_file_and_status_flags_tb_top;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    crf_pkg::crf_scheme_t sch = crf_pkg::CRF_SCHEME_NONE;
    crf_pkg::crf_alu_op_t op = crf_pkg::CRF_ALU_ADD;
    logic [4:0] sa = 5'h00, sb = 5'h00, dst = 5'h00;
    logic uimm = 1'b0, iord = 1'b0, iowr = 1'b0, dsrd = 1'b0, dswr = 1'b0;
    logic bit_store_instr = 1'b0, bit_load_instr = 1'b0, set_global_enable_instr = 1'b0, cli = 1'b0, return_from_irq_instr = 1'b0, fen = 1'b0;
    logic [7:0] imm = 8'h00, wd = 8'h00, irq = 8'h00, rdo, flg, ext;
    logic [1:0] psel = 2'h0;
    logic [5:0] ioa = 6'h00;
    logic [2:0] bsel = 3'h0, inum;
    logic [15:0] dsa = 16'h0000, ptr, tptr, instr, pmem;
    logic iosel, extsel, take;
    int bad_count = 0;
    int checks = 0;

    crf_far_model far_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .ds_addr_in(dsa),
        .pmem_data_out(pmem), .ext_data_out(ext));
    crf_core dut_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .scheme_in(sch),
        .alu_op_in(op), .use_carry_in(1'b0), .src_a_in(sa), .src_b_in(sb), .dst_in(dst),
        .use_imm_in(uimm), .imm_in(imm), .wide_src_in(1'b0), .ptr_sel_in(psel),
        .io_rd_in(iord), .io_wr_in(iowr), .io_addr_in(ioa), .ds_rd_in(dsrd),
        .ds_wr_in(dswr), .ds_addr_in(dsa), .wr_data_in(wd), .ext_rd_data_in(ext),
        .bit_store_instr_in(bit_store_instr), .bit_load_instr_in(bit_load_instr), .bit_sel_in(bsel),
        .set_global_enable_instr_in(set_global_enable_instr), .clear_global_enable_instr_in(cli),
        .return_from_irq_instr_in(return_from_irq_instr), .irq_req_in(irq), .pmem_data_in(pmem),
        .fetch_en_in(fen), .rd_data_out(rdo), .ptr_out(ptr), .table_ptr_out(tptr),
        .status_flags_out(flg), .io_sel_out(iosel), .ext_sel_out(extsel),
        .irq_take_out(take), .irq_num_out(inum), .instr_out(instr));

    initial begin
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask

    task automatic final_report();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One access in I/O or data space; a read compares the registered data a cycle on.
    task automatic acc(input logic io, input logic w, input logic [15:0] a,
        input logic [7:0] d);
        @(posedge sys_clk_in);
        ioa <= a[5:0];
        dsa <= a;
        wd <= d;
        iowr <= io & w;
        dswr <= !io & w;
        iord <= io & !w;
        dsrd <= !io & !w;
        @(posedge sys_clk_in);
        {iowr, dswr, iord, dsrd} <= 4'h0;
        #1;
        if (!w) begin
            chk(rdo, d);
        end
    endtask

    task automatic alu(input crf_pkg::crf_scheme_t s, input crf_pkg::crf_alu_op_t o,
        input logic [4:0] a, input logic [4:0] b, input logic [4:0] d);
        @(posedge sys_clk_in);
        sch <= s;
        op <= o;
        sa <= a;
        sb <= b;
        dst <= d;
        @(posedge sys_clk_in);
        sch <= crf_pkg::CRF_SCHEME_NONE;
        #1;
    endtask

    initial begin
        repeat (4000) @(posedge sys_clk_in);
        bad_count++;
        final_report();
    end

    initial begin
        repeat (8) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        #1;
        chk(flg, 16'h0000);
        chk(rdo, 16'h0000);
        chk(instr, 16'h0000);
        acc(1'b0, 1'b1, 16'h0001, 8'h0f);
        acc(1'b0, 1'b1, 16'h0002, 8'h01);
        acc(1'b0, 1'b0, 16'h0001, 8'h0f);
        alu(crf_pkg::CRF_SCHEME_2OP8, crf_pkg::CRF_ALU_ADD, 5'h01, 5'h02, 5'h03);
        chk(flg, 16'h0020);
        acc(1'b0, 1'b0, 16'h0003, 8'h10);
        acc(1'b0, 1'b1, 16'h0004, 8'h80);
        alu(crf_pkg::CRF_SCHEME_2OP8, crf_pkg::CRF_ALU_ADD, 5'h04, 5'h04, 5'h05);
        chk(flg, 16'h001b);
        alu(crf_pkg::CRF_SCHEME_2OP8, crf_pkg::CRF_ALU_SUB, 5'h05, 5'h02, 5'h06);
        chk(flg, 16'h0035);
        acc(1'b0, 1'b0, 16'h0006, 8'hff);
        alu(crf_pkg::CRF_SCHEME_1OP8, crf_pkg::CRF_ALU_MOV, 5'h00, 5'h01, 5'h07);
        acc(1'b0, 1'b0, 16'h0007, 8'h0f);
        acc(1'b0, 1'b1, 16'h001a, 8'hff);
        acc(1'b0, 1'b1, 16'h001b, 8'h12);
        chk(ptr, 16'h12ff);
        @(posedge sys_clk_in);
        uimm <= 1'b1;
        imm <= 8'h01;
        alu(crf_pkg::CRF_SCHEME_2OP16, crf_pkg::CRF_ALU_ADIW, 5'h1a, 5'h00, 5'h1a);
        chk(ptr, 16'h1300);
        acc(1'b0, 1'b1, 16'h001e, 8'h34);
        acc(1'b0, 1'b1, 16'h001f, 8'h56);
        chk(tptr, 16'h5634);
        @(posedge sys_clk_in);
        uimm <= 1'b0;
        psel <= 2'h2;
        sa <= 5'h01;
        bsel <= 3'h3;
        bit_store_instr <= 1'b1;
        @(posedge sys_clk_in);
        bit_store_instr <= 1'b0;
        dsa <= 16'h0040;
        dsrd <= 1'b1;
        #1;
        chk(ptr, 16'h5634);
        chk(flg[6], 16'h0001);
        chk({iosel, extsel}, 16'h0002);
        @(posedge sys_clk_in);
        dsa <= 16'h0080;
        #1;
        chk({iosel, extsel}, 16'h0001);
        acc(1'b0, 1'b0, 16'h0080, 8'h7f);
        acc(1'b1, 1'b1, 16'h003f, 8'hc0);
        acc(1'b0, 1'b0, 16'h005f, 8'hc0);
        @(posedge sys_clk_in);
        irq <= 8'h24;
        #1;
        chk({take, inum}, 16'h000a);
        @(posedge sys_clk_in);
        irq <= 8'h01;
        #1;
        chk(flg, 16'h0040);
        chk(take, 16'h0000);
        @(posedge sys_clk_in);
        irq <= 8'h00;
        return_from_irq_instr <= 1'b1;
        @(posedge sys_clk_in);
        return_from_irq_instr <= 1'b0;
        cli <= 1'b1;
        irq <= 8'h01;
        #1;
        chk(flg, 16'h00c0);
        chk(take, 16'h0000);
        @(posedge sys_clk_in);
        cli <= 1'b0;
        irq <= 8'h00;
        set_global_enable_instr <= 1'b1;
        #1;
        chk(flg, 16'h0040);
        @(posedge sys_clk_in);
        set_global_enable_instr <= 1'b0;
        fen <= 1'b1;
        #1;
        chk(flg, 16'h00c0);
        repeat (2) begin
            @(posedge sys_clk_in);
            #1;
            chk(instr, pmem - 16'h0001);
        end
        @(posedge sys_clk_in);
        rst_n_in <= 1'b0;
        @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        #1;
        chk(flg, 16'h0000);
        final_report();
    end
endmodule
